// ---- src/acs_top.sv ----
// Purpose: inband command decoder and status generator for a speech codec
// Assumes: command words arrive as a valid-qualified stream, eight header words
// Notes:   codec data words after word 7 are not handled here
//
// Overview of operation
// - checksum equals signed 16-bit sum of command words 2..7
// - bad checksum keeps settings and flags error in next status
// - mode word: encoder select upper nibble, decoder lower, codes 0..6
// - mode word all ones restores power-on defaults
// - mute bits change gain by gradual ramp
// - G.722 bit limit: 00 eight, 01 seven, 10 six, 11 reserved; code 11 is passed to the core with no error flag
// - G.723 encode field selects rate and silence suppression
// - rate bit selects 8/16 kHz, resampling added when mismatched; with G.722 on one side only, resample_en follows the G.722 side alone
// - G.728 with 16 kHz codec disables postfilter
// - G.722 with 8 kHz codec limits band to 3.4 kHz
// - loopback codes 000,001,010,101,110 valid; others reserved
// - part number counts 0..2 in G.723, zero otherwise
// - invalid bit: data still sent, flagged data not decoded
// - volume: encoder gain high byte, decoder low; scale (g+1)/256
// - status mode/options/volume describe output pipeline stage
// - capabilities report coder flags, symmetry one, codec connected bit 0 following codec_present
// - error word bits: checksum, mode, loopback, hardware, timing
// - new control first shows in status three frames later
// - four neutral packets needed before new mode
// - G.711 command in packet n shows in status at n+3
// - one command and one status packet per 10 ms
// - status packet: header, caps, mode, options, volume, error, two reserved
`timescale 1ns/1ps
module acs_top #(
  parameter int unsigned FRAME_CYCLES = acs_pkg::FRAME_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  input  wire logic        status_ready,
  input  wire logic        hw_fault,
  input  wire logic        codec_present,
  output logic             status_valid,
  output logic [15:0]      status_word,
  output logic             frame_tick,
  output acs_pkg::acs_core_s core_cfg,
  output logic [8:0]       encoder_gain,
  output logic [8:0]       decoder_gain,
  output logic             mode_change_ok
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic code_ok(input logic [3:0] c);
    code_ok = (c <= acs_pkg::CODE_MPMLQ);
  endfunction

  function automatic logic loop_ok(input logic [2:0] l);
    loop_ok = (l == acs_pkg::LOOP_NONE) || (l == acs_pkg::LOOP_COMP) ||
              (l == acs_pkg::LOOP_REENC) || (l == acs_pkg::LOOP_DECENC) ||
              (l == acs_pkg::LOOP_ANALOG);
  endfunction

  function automatic logic [8:0] mute_gain(input logic mute, input logic [7:0] g);
    mute_gain = mute ? 9'h000 : ({1'b0, g} + 9'h001);
  endfunction

  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = (p == 2'h2) ? 2'h0 : p + 2'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] valid_sync_reg;
  logic [1:0] fault_sync_reg;
  logic [1:0] codec_sync_reg;
  logic [1:0] ready_sync_reg;
  logic [15:0] word_s1_reg;
  logic [15:0] word_s2_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      valid_sync_reg <= '0;
      fault_sync_reg <= '0;
      codec_sync_reg <= 2'h3;
      ready_sync_reg <= '0;
      word_s1_reg    <= '0;
      word_s2_reg    <= '0;
    end else begin
      valid_sync_reg <= {valid_sync_reg[0], cmd_valid};
      fault_sync_reg <= {fault_sync_reg[0], hw_fault};
      codec_sync_reg <= {codec_sync_reg[0], codec_present};
      ready_sync_reg <= {ready_sync_reg[0], status_ready};
      word_s1_reg    <= cmd_word;
      word_s2_reg    <= word_s1_reg;
    end
  end

  wire logic        in_valid = valid_sync_reg[1];
  wire logic [15:0] in_word  = word_s2_reg;

  ////////////////////////////////////////////////////////////////////////
  // command receive and frame timing

  logic [31:0]  frame_cnt_reg,  frame_cnt_next;
  logic [3:0]   rx_idx_reg,     rx_idx_next;
  logic [15:0]  sum_reg,        sum_next;
  logic [15:0]  rx_sum_reg,     rx_sum_next;
  acs_pkg::acs_ctrl_s rx_reg,   rx_next;
  acs_pkg::acs_ctrl_s cur_reg,  cur_next;
  logic         got_pkt_reg,    got_pkt_next;
  logic [4:0]   err_reg,        err_next;
  logic [1:0]   wptr_reg,       wptr_next;
  logic [2:0]   neutral_reg,    neutral_next;
  logic [1:0]   part_reg,       part_next;
  logic         tick_reg,       tick_next;

  wire logic boundary = (frame_cnt_reg == FRAME_CYCLES - 1);

  always_comb begin
    frame_cnt_next = boundary ? 32'h0 : frame_cnt_reg + 32'h1;
    rx_idx_next    = rx_idx_reg;
    sum_next       = sum_reg;
    rx_sum_next    = rx_sum_reg;
    rx_next        = rx_reg;
    cur_next       = cur_reg;
    got_pkt_next   = got_pkt_reg;
    err_next       = err_reg;
    wptr_next      = wptr_reg;
    neutral_next   = neutral_reg;
    part_next      = part_reg;
    tick_next      = boundary;
    if (in_valid && rx_idx_reg < acs_pkg::HDR_WORDS[3:0]) begin
      unique case (rx_idx_reg[2:0])
        acs_pkg::CW_CHECKSUM: rx_sum_next     = in_word;
        acs_pkg::CW_MODE:     rx_next.mode    = in_word;
        acs_pkg::CW_OPTIONS:  rx_next.options = in_word;
        acs_pkg::CW_VOLUME:   rx_next.volume  = in_word;
        default: ;
      endcase
      if (rx_idx_reg >= 4'h2) begin
        sum_next = sum_reg + in_word;
      end
      rx_idx_next = rx_idx_reg + 4'h1;
      if (rx_idx_reg == 4'h7) begin
        got_pkt_next = 1'b1;
      end
    end
    if (fault_sync_reg[1]) begin
      err_next[acs_pkg::ERR_HW] = 1'b1;
    end
    if (boundary) begin
      rx_idx_next  = '0;
      sum_next     = '0;
      got_pkt_next = 1'b0;
      wptr_next    = ptr_inc(wptr_reg);
      err_next     = '0;
      err_next[acs_pkg::ERR_HW] = fault_sync_reg[1];
      if (!got_pkt_reg) begin
        err_next[acs_pkg::ERR_TIMING] = 1'b1;
      end else if (sum_reg != rx_sum_reg) begin
        err_next[acs_pkg::ERR_CHECKSUM] = 1'b1;
      end else if (rx_reg.mode == acs_pkg::MODE_RESET) begin
        cur_next     = '{acs_pkg::MODE_DEFAULT, acs_pkg::OPT_DEFAULT,
                         acs_pkg::VOL_DEFAULT};
        neutral_next = acs_pkg::NEUTRAL_NEEDED[2:0];
      end else if (!code_ok(rx_reg.mode[7:4]) || !code_ok(rx_reg.mode[3:0])) begin
        err_next[acs_pkg::ERR_MODE] = 1'b1;
      end else if (!loop_ok(rx_reg.options[acs_pkg::OPT_LOOP_LSB +: 3])) begin
        err_next[acs_pkg::ERR_LOOP] = 1'b1;
      end else if (rx_reg.mode[7:0] != 8'h00 && rx_reg.mode[7:0] != cur_reg.mode[7:0] &&
                   neutral_reg < acs_pkg::NEUTRAL_NEEDED[2:0]) begin
        err_next[acs_pkg::ERR_MODE] = 1'b1;
      end else begin
        cur_next = rx_reg;
      end
      // neutral run counter on the applied stage
      if (cur_next.mode[7:0] == 8'h00) begin
        if (neutral_next < acs_pkg::NEUTRAL_NEEDED[2:0]) begin
          neutral_next = neutral_next + 3'h1;
        end
      end else begin
        neutral_next = '0;
      end
      part_next = (cur_next.mode[7:4] == acs_pkg::CODE_MPMLQ) ?
                  ((part_reg == 2'h2) ? 2'h0 : part_reg + 2'h1) : 2'h0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_cnt_reg <= '0;
      rx_idx_reg    <= '0;
      sum_reg       <= '0;
      rx_sum_reg    <= '0;
      rx_reg        <= '0;
      cur_reg       <= '0;
      got_pkt_reg   <= 1'b1;
      err_reg       <= '0;
      wptr_reg      <= '0;
      neutral_reg   <= acs_pkg::NEUTRAL_NEEDED[2:0];
      part_reg      <= '0;
      tick_reg      <= 1'b0;
    end else begin
      frame_cnt_reg <= frame_cnt_next;
      rx_idx_reg    <= rx_idx_next;
      sum_reg       <= sum_next;
      rx_sum_reg    <= rx_sum_next;
      rx_reg        <= rx_next;
      cur_reg       <= cur_next;
      got_pkt_reg   <= got_pkt_next;
      err_reg       <= err_next;
      wptr_reg      <= wptr_next;
      neutral_reg   <= neutral_next;
      part_reg      <= part_next;
      tick_reg      <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settings pipeline: a command packet shows in status three frames later

  acs_pkg::acs_ctrl_s out_stage;
  acs_pkg::acs_ctrl_s stage_in;

  always_comb begin
    stage_in = cur_reg;
    stage_in.options[acs_pkg::OPT_PART_LSB +: 2] = part_reg;
  end

  acs_stage_mem u_stage (
    .clk         (clk),
    .resetn      (resetn),
    .wr_en       (tick_reg),
    .wr_addr     (wptr_reg),
    .wr_data     (stage_in),
    .rd_addr     (ptr_inc(wptr_reg)),
    .rd_data_reg (out_stage)
  );

  ////////////////////////////////////////////////////////////////////////
  // core configuration decode

  acs_pkg::acs_core_s core_next;
  logic [3:0] enc_sel;
  logic [3:0] dec_sel;
  logic       rate16;

  always_comb begin
    enc_sel   = cur_reg.mode[7:4];
    dec_sel   = cur_reg.mode[3:0];
    rate16    = cur_reg.options[acs_pkg::OPT_RATE];
    core_next = '0;
    core_next.encoder_coding_select = enc_sel;
    core_next.decoder_coding_select = dec_sel;
    core_next.dec_mute = cur_reg.options[acs_pkg::OPT_DEC_MUTE];
    core_next.enc_mute = cur_reg.options[acs_pkg::OPT_ENC_MUTE];
    core_next.loopback = cur_reg.options[acs_pkg::OPT_LOOP_LSB +: 3];
    core_next.rate_16k = rate16;
    core_next.data_invalid = cur_reg.options[acs_pkg::OPT_INVALID];
    if (enc_sel == acs_pkg::CODE_WIDE) begin
      core_next.encode_bit_limit = cur_reg.options[acs_pkg::OPT_RE_LSB +: 2];
    end
    if (dec_sel == acs_pkg::CODE_WIDE) begin
      core_next.decode_bit_limit = cur_reg.options[acs_pkg::OPT_RD_LSB +: 2];
    end
    if (enc_sel == acs_pkg::CODE_MPMLQ) begin
      core_next.mpmlq_method = cur_reg.options[acs_pkg::OPT_RE_LSB +: 2];
    end
    // wideband coder is native 16 kHz, all others native 8 kHz
    core_next.resample_en = (enc_sel == acs_pkg::CODE_WIDE || dec_sel == acs_pkg::CODE_WIDE)
                            ? !rate16 : (rate16 && cur_reg.mode[7:0] != 8'h00);
    core_next.postfilter_off = rate16 && (dec_sel == acs_pkg::CODE_LDCELP);
    core_next.band_limit = !rate16 && (enc_sel == acs_pkg::CODE_WIDE ||
                                       dec_sel == acs_pkg::CODE_WIDE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_cfg       <= '0;
      frame_tick     <= 1'b0;
      mode_change_ok <= 1'b1;
    end else begin
      core_cfg       <= core_next;
      frame_tick     <= tick_reg;
      mode_change_ok <= (neutral_reg == acs_pkg::NEUTRAL_NEEDED[2:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gain ramps

  acs_gain_ramp u_enc_ramp (
    .clk       (clk),
    .resetn    (resetn),
    .target    (mute_gain(core_cfg.enc_mute, cur_reg.volume[15:8])),
    .scale_reg (encoder_gain)
  );

  acs_gain_ramp u_dec_ramp (
    .clk       (clk),
    .resetn    (resetn),
    .target    (mute_gain(core_cfg.dec_mute, cur_reg.volume[7:0])),
    .scale_reg (decoder_gain)
  );

  ////////////////////////////////////////////////////////////////////////
  // status packet transmit

  logic [3:0]  tx_idx_reg,  tx_idx_next;
  logic        tx_val_reg,  tx_val_next;
  logic [15:0] tx_word_reg, tx_word_next;
  logic [4:0]  tx_err_reg,  tx_err_next;

  always_comb begin
    tx_idx_next  = tx_idx_reg;
    tx_val_next  = 1'b0;
    tx_word_next = tx_word_reg;
    tx_err_next  = tx_err_reg;
    if (tick_reg) begin
      tx_idx_next = '0;
      tx_err_next = err_reg;
    end else if (tx_idx_reg < acs_pkg::HDR_WORDS[3:0] && ready_sync_reg[1]) begin
      tx_val_next = 1'b1;
      tx_idx_next = tx_idx_reg + 4'h1;
      unique case (tx_idx_reg[2:0])
        3'h0:                tx_word_next = acs_pkg::STATUS_HEADER;
        acs_pkg::SW_CAPS:    tx_word_next = {acs_pkg::CAPS_WORD[15:1],
                                             codec_sync_reg[1]};
        acs_pkg::SW_MODE:    tx_word_next = out_stage.mode;
        acs_pkg::SW_OPTIONS: tx_word_next = out_stage.options;
        acs_pkg::SW_VOLUME:  tx_word_next = out_stage.volume;
        acs_pkg::SW_ERROR:   tx_word_next = {11'h000, tx_err_reg};
        default:             tx_word_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_idx_reg  <= acs_pkg::HDR_WORDS[3:0];
      tx_val_reg  <= 1'b0;
      tx_word_reg <= '0;
      tx_err_reg  <= '0;
    end else begin
      tx_idx_reg  <= tx_idx_next;
      tx_val_reg  <= tx_val_next;
      tx_word_reg <= tx_word_next;
      tx_err_reg  <= tx_err_next;
    end
  end

  always_comb begin
    status_valid = tx_val_reg;
    status_word  = tx_word_reg;
  end

endmodule // acs_top

// ---- src/acs_pkg.sv ----
// Purpose: shared constants and carriers of the command/status interpreter
// Assumes: 16-bit packet words, one packet each way per 10 ms frame
// Notes:   offsets, field positions, default settings, header and neutral counts live here
package acs_pkg;

  // packet layout
  localparam int unsigned HDR_WORDS     = 8;
  localparam logic [2:0]  CW_HEADER     = 3'h0;
  localparam logic [2:0]  CW_CHECKSUM   = 3'h1;
  localparam logic [2:0]  CW_MODE       = 3'h2;
  localparam logic [2:0]  CW_OPTIONS    = 3'h3;
  localparam logic [2:0]  CW_VOLUME     = 3'h4;
  localparam logic [2:0]  SW_CAPS       = 3'h1;
  localparam logic [2:0]  SW_MODE       = 3'h2;
  localparam logic [2:0]  SW_OPTIONS    = 3'h3;
  localparam logic [2:0]  SW_VOLUME     = 3'h4;
  localparam logic [2:0]  SW_ERROR      = 3'h5;
  localparam logic [15:0] STATUS_HEADER = 16'h480f;
  localparam logic [15:0] MODE_RESET    = 16'hffff;

  // coding select codes
  localparam logic [3:0] CODE_NEUTRAL = 4'h0;
  localparam logic [3:0] CODE_LINEAR  = 4'h1;
  localparam logic [3:0] CODE_ALAW    = 4'h2;
  localparam logic [3:0] CODE_MULAW   = 4'h3;
  localparam logic [3:0] CODE_WIDE    = 4'h4;
  localparam logic [3:0] CODE_LDCELP  = 4'h5;
  localparam logic [3:0] CODE_MPMLQ   = 4'h6;

  // options word fields
  localparam int unsigned OPT_DEC_MUTE  = 0;
  localparam int unsigned OPT_ENC_MUTE  = 1;
  localparam int unsigned OPT_RD_LSB    = 2;
  localparam int unsigned OPT_RE_LSB    = 4;
  localparam int unsigned OPT_RATE      = 6;
  localparam int unsigned OPT_LOOP_LSB  = 8;
  localparam int unsigned OPT_PART_LSB  = 11;
  localparam int unsigned OPT_INVALID   = 15;

  // loopback codes
  localparam logic [2:0] LOOP_NONE    = 3'h0;
  localparam logic [2:0] LOOP_COMP    = 3'h1;
  localparam logic [2:0] LOOP_REENC   = 3'h2;
  localparam logic [2:0] LOOP_DECENC  = 3'h5;
  localparam logic [2:0] LOOP_ANALOG  = 3'h6;

  // bit limit codes
  localparam logic [1:0] LIMIT_8     = 2'h0;
  localparam logic [1:0] LIMIT_7     = 2'h1;
  localparam logic [1:0] LIMIT_6     = 2'h2;
  localparam logic [1:0] LIMIT_RSVD  = 2'h3;

  // error word bits
  localparam int unsigned ERR_CHECKSUM = 0;
  localparam int unsigned ERR_MODE     = 1;
  localparam int unsigned ERR_LOOP     = 2;
  localparam int unsigned ERR_HW       = 3;
  localparam int unsigned ERR_TIMING   = 4;

  // capability bits
  localparam logic [15:0] CAPS_WORD = 16'h00ff;

  // reset values
  localparam logic [15:0] MODE_DEFAULT = 16'h0000;
  localparam logic [15:0] OPT_DEFAULT  = 16'h0000;
  localparam logic [15:0] VOL_DEFAULT  = 16'h0000;

  // timing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned FRAME_US       = 10000;
  localparam int unsigned FRAME_CYCLES   = FRAME_US * CLK_MHZ;
  localparam int unsigned NEUTRAL_NEEDED = 4;
  localparam int unsigned RAMP_STEP_LOG2 = 4;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] options;
    logic [15:0] volume;
  } acs_ctrl_s;

  typedef struct packed {
    logic        dec_mute;
    logic        enc_mute;
    logic [1:0]  encode_bit_limit;
    logic [1:0]  decode_bit_limit;
    logic [2:0]  loopback;
    logic        rate_16k;
    logic        resample_en;
    logic        postfilter_off;
    logic        band_limit;
    logic        data_invalid;
    logic [1:0]  mpmlq_method;
    logic [3:0]  encoder_coding_select;
    logic [3:0]  decoder_coding_select;
  } acs_core_s;

endpackage

// ---- src/acs_stage_mem.sv ----
// Purpose: three-deep control pipeline storage with registered read
// Assumes: one write per frame boundary; the read register reloads every cycle
// Notes:   read data come out of a register
`timescale 1ns/1ps
module acs_stage_mem (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              wr_en,
  input  wire logic [1:0]        wr_addr,
  input  wire acs_pkg::acs_ctrl_s wr_data,
  input  wire logic [1:0]        rd_addr,
  output acs_pkg::acs_ctrl_s     rd_data_reg
);

  acs_pkg::acs_ctrl_s mem_reg [3];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 3; i++) begin
        mem_reg[i] <= '0;
      end
      rd_data_reg <= '0;
    end else begin
      if (wr_en) begin
        mem_reg[wr_addr] <= wr_data;
      end
      rd_data_reg <= mem_reg[rd_addr];
    end
  end

endmodule // acs_stage_mem

// ---- src/acs_gain_ramp.sv ----
// Purpose: gradual gain ramp toward a target so mute never clicks
// Assumes: target changes at frame boundaries
// Notes:   gain is (value+1)/256 applied downstream; 9-bit scale 0..256
`timescale 1ns/1ps
module acs_gain_ramp (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [8:0] target,
  output logic      [8:0] scale_reg
);

  logic [acs_pkg::RAMP_STEP_LOG2-1:0] div_reg;
  logic [acs_pkg::RAMP_STEP_LOG2-1:0] div_next;
  logic [8:0]                         scale_next;

  // step one unit every few cycles instead of jumping
  always_comb begin
    div_next   = div_reg + 1'b1;
    scale_next = scale_reg;
    if (div_reg == '0) begin
      if (scale_reg < target) begin
        scale_next = scale_reg + 9'h001;
      end else if (scale_reg > target) begin
        scale_next = scale_reg - 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg   <= '0;
      scale_reg <= 9'h001;
    end else begin
      div_reg   <= div_next;
      scale_reg <= scale_next;
    end
  end

endmodule // acs_gain_ramp

// ---- verification/acs_user_model.sv ----
// Purpose: user side model, one command packet per frame
// Assumes: frame_tick marks each frame boundary
// Notes:   CMD_HEADER value is arbitrary
`timescale 1ns/1ps
module acs_user_model #(parameter logic [15:0] CMD_HEADER = 16'h080f) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        frame_tick,
  input  wire logic [15:0] mode,
  input  wire logic [15:0] options,
  input  wire logic [15:0] volume,
  input  wire logic        bad_sum,
  input  wire logic        skip,
  output logic             cmd_valid,
  output logic [15:0]      cmd_word
);
  logic [1:0] part = 2'h0;
  ////////////////////////////////
  task automatic send_pkt();
    logic [15:0] w [8];
    logic [15:0] o;
    o = options;
    if (mode[3:0] == acs_pkg::CODE_MPMLQ) begin
      o[acs_pkg::OPT_RD_LSB +: 2] = o[acs_pkg::OPT_RE_LSB +: 2];
      o[acs_pkg::OPT_PART_LSB +: 2] = part;
      part = (part == 2'h2) ? 2'h0 : part + 2'h1;
    end
    w = '{CMD_HEADER, 16'h0, mode, o, volume, 16'h0, 16'h0, 16'h0};
    w[1] = mode + o + volume + {15'h0, bad_sum};
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_word = w[i];
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_word = ~w[7];
  endtask
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0;
    @(posedge resetn);
    send_pkt();
    forever begin
      @(posedge clk iff frame_tick);
      if (!skip) send_pkt();
    end
  end
endmodule // acs_user_model

// ---- verification/acs_top_chk.sv ----
// Purpose: port assertions on acs_top
// Assumes: status_ready held high
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module acs_top_chk #(parameter int unsigned FRAME_CYCLES = 200) (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               status_ready,
  input wire logic               status_valid,
  input wire logic [15:0]        status_word,
  input wire logic               frame_tick,
  input wire acs_pkg::acs_core_s core_cfg,
  input wire logic [8:0]         encoder_gain
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  int unsigned gap_reg;
  logic        seen_reg;
  ////////////////////////////////
  // cycles since the last frame tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= 0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= frame_tick ? 0 : gap_reg + 1;
      seen_reg <= seen_reg | frame_tick;
    end
  end
  sequence tick_s;
    frame_tick && status_ready;
  endsequence
  sequence burst_s;
    status_valid [*8] ##1 !status_valid;
  endsequence
  frame_gap_a:
    assert property (frame_tick && seen_reg |-> gap_reg == FRAME_CYCLES - 1)
    else $error("frame gap");
  word_count_a:
    assert property (tick_s |-> ##1 burst_s)
    else $error("status length");
  header_word_a:
    assert property (tick_s ##1 1'b1 |-> status_word == acs_pkg::STATUS_HEADER)
    else $error("status header");
  caps_word_a:
    assert property (tick_s ##2 1'b1 |-> status_word[15:1] == acs_pkg::CAPS_WORD[15:1])
    else $error("caps word");
  mode_word_a:
    assert property (tick_s ##3 1'b1 |-> status_word[15:8] == 8'h00
      && status_word[7:4] <= 4'h6 && status_word[3:0] <= 4'h6)
    else $error("mode word");
  error_word_a:
    assert property (tick_s ##6 1'b1 |-> status_word[15:5] == 11'h000)
    else $error("error word");
  gain_step_a:
    assert property (encoder_gain != $past(encoder_gain) |->
      encoder_gain - $past(encoder_gain) == 9'h1 || $past(encoder_gain) - encoder_gain == 9'h1)
    else $error("gain jump");
  postfilter_a:
    assert property (core_cfg.postfilter_off == (core_cfg.rate_16k &&
      core_cfg.decoder_coding_select == acs_pkg::CODE_LDCELP))
    else $error("postfilter");
  band_limit_a:
    assert property (core_cfg.band_limit == (!core_cfg.rate_16k &&
      (core_cfg.encoder_coding_select == acs_pkg::CODE_WIDE ||
       core_cfg.decoder_coding_select == acs_pkg::CODE_WIDE)))
    else $error("band limit");
endmodule // acs_top_chk
bind acs_top acs_top_chk #(.FRAME_CYCLES(FRAME_CYCLES)) u_acs_top_chk (
  .clk(clk), .resetn(resetn), .status_ready(status_ready), .status_valid(status_valid),
  .status_word(status_word), .frame_tick(frame_tick), .core_cfg(core_cfg),
  .encoder_gain(encoder_gain));

// ---- verification/test_audio_codec_command_status.sv ----
// Purpose: self-checking bench for the command/status interpreter
// Assumes: frame shortened to 200 cycles
// Notes:   st holds the eight status words of the latest frame
`timescale 1ns/1ps
module test_audio_codec_command_status;
  localparam int unsigned FC = 200;
  logic               clk, cmd_valid, status_valid, frame_tick, mode_change_ok;
  logic               resetn = 1'b0, hw_fault = 1'b0, bad_sum = 1'b0, skip = 1'b0;
  logic               status_ready = 1'b1, codec_present = 1'b1;
  logic [15:0]        cmd_word, status_word;
  logic [15:0]        mode = 16'h0, options = 16'h0, volume = 16'h0;
  logic [8:0]         encoder_gain, decoder_gain;
  acs_pkg::acs_core_s core_cfg;
  logic [15:0]        st [8];
  logic [2:0]         lb [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h0};
  int                 idx = 0, cyc = 0, failures = 0, n_tests = 0;
  acs_top #(.FRAME_CYCLES(FC)) u_acs_top (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .status_ready(status_ready), .hw_fault(hw_fault), .codec_present(codec_present),
    .status_valid(status_valid), .status_word(status_word), .frame_tick(frame_tick),
    .core_cfg(core_cfg), .encoder_gain(encoder_gain), .decoder_gain(decoder_gain),
    .mode_change_ok(mode_change_ok));
  acs_user_model u_acs_user_model (
    .clk(clk), .resetn(resetn), .frame_tick(frame_tick), .mode(mode), .options(options),
    .volume(volume), .bad_sum(bad_sum), .skip(skip), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word));
  ////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk iff frame_tick);
      repeat (12) @(posedge clk);
    end
  endtask
  task automatic cmd(input logic [15:0] m, o, v, input logic b = 1'b0);
    @(negedge clk);
    mode = m;
    options = o;
    volume = v;
    bad_sum = b;
  endtask
  task automatic seek(input int b, input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      frames(1);
      hit = hit | st[5][b];
    end
    chk({15'h0, hit}, 16'h0001, "error bit");
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // capture status words and cut a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (frame_tick) idx = 0;
    else if (status_valid && idx < 8) begin
      st[idx] = status_word;
      idx = idx + 1;
    end
    if (cyc == 40000) begin
      failures = failures + 1;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    frames(2);
    chk(st[0], acs_pkg::STATUS_HEADER, "header");
    chk(st[1], acs_pkg::CAPS_WORD, "caps");
    chk(st[5], 16'h0000, "idle error");
    $display("test idle done");
    cmd(16'h0022, 16'h0000, 16'h80c0);
    frames(3);
    chk(st[2], 16'h0000, "mode early");
    frames(1);
    chk(st[2], 16'h0022, "mode");
    chk(st[4], 16'h80c0, "volume");
    chk({12'h0, core_cfg.encoder_coding_select}, 16'h0002, "enc select");
    frames(14);
    chk({7'h0, encoder_gain}, 16'h0081, "enc gain");
    chk({7'h0, decoder_gain}, 16'h00c1, "dec gain");
    $display("test g711 done");
    cmd(16'h0022, 16'h0001, 16'h80c0);
    frames(5);
    chk({15'h0, decoder_gain != 9'h0}, 16'h0001, "abrupt mute");
    frames(16);
    chk({7'h0, decoder_gain}, 16'h0000, "muted gain");
    chk(st[3], 16'h0001, "options");
    $display("test mute done");
    cmd(16'h0022, 16'h0001, 16'h1111, 1'b1);
    seek(acs_pkg::ERR_CHECKSUM, 3);
    frames(3);
    chk(st[4], 16'h80c0, "bad sum applied");
    cmd(16'h0022, 16'h0301, 16'h80c0);
    seek(acs_pkg::ERR_LOOP, 3);
    foreach (lb[i]) begin
      cmd(16'h0022, {5'h0, lb[i], 8'h01}, 16'h80c0);
      frames(5);
      chk(st[3], {5'h0, lb[i], 8'h01}, "loopback");
    end
    $display("test errors done");
    cmd(16'h0000, 16'h0000, 16'h80c0);
    frames(2);
    cmd(16'h0033, 16'h0000, 16'h80c0);
    chk({15'h0, mode_change_ok}, 16'h0000, "early change");
    seek(acs_pkg::ERR_MODE, 4);
    cmd(16'hffff, 16'h0000, 16'h0000);
    frames(6);
    chk(st[2], 16'h0000, "reset mode");
    chk(st[4], 16'h0000, "reset volume");
    chk({15'h0, mode_change_ok}, 16'h0001, "reset ready");
    $display("test mode change done");
    cmd(16'h0055, 16'h0040, 16'h0000);
    frames(5);
    chk({14'h0, core_cfg.postfilter_off, core_cfg.resample_en}, 16'h0003, "g728");
    cmd(16'h0000, 16'h0000, 16'h0000);
    frames(7);
    cmd(16'h0044, 16'h0014, 16'h0000);
    frames(5);
    chk({14'h0, core_cfg.band_limit, core_cfg.resample_en}, 16'h0003, "g722");
    chk({12'h0, core_cfg.encode_bit_limit, core_cfg.decode_bit_limit}, 16'h0005, "limit");
    cmd(16'h0000, 16'h0000, 16'h0000);
    frames(5);
    cmd(16'h0066, 16'h0020, 16'h0000);
    frames(5);
    chk({14'h0, core_cfg.mpmlq_method}, 16'h0002, "g723 method");
    $display("test coders done");
    @(negedge clk);
    skip = 1'b1;
    frames(1);
    skip = 1'b0;
    seek(acs_pkg::ERR_TIMING, 3);
    @(negedge clk);
    hw_fault = 1'b1;
    codec_present = 1'b0;
    frames(2);
    chk({15'h0, st[5][3]}, 16'h0001, "hw fault");
    chk({15'h0, st[1][0]}, 16'h0000, "codec absent");
    $display("test faults done");
    close_out();
  end
endmodule // test_audio_codec_command_status
